// [ppfs_consts.vh]
// constants for the port pin function select block
// assumes it is included by bare name from the design files
`ifndef PPFS_CONSTS_VH
`define PPFS_CONSTS_VH

// ==========================================================
// port codes carried on cfg_port_i
// ==========================================================
`define PPFS_PORT0 3'h0
`define PPFS_PORT2 3'h1
`define PPFS_PORT4 3'h2
`define PPFS_PORT5 3'h3
`define PPFS_PORT6 3'h4
`define PPFS_PORT8 3'h5
`define PPFS_PORTC 3'h6

// ==========================================================
// field codes carried on cfg_field_i
// ==========================================================
`define PPFS_FLD_DIR 2'h0
`define PPFS_FLD_PLU 2'h1
`define PPFS_FLD_DAT 2'h2
`define PPFS_FLD_FUNC 2'h3

// ==========================================================
// per-bit reset values: input mode, pull-up off, ordinary port
// ==========================================================
`define PPFS_DIR_RST 1'b0
`define PPFS_PLU_RST 1'b0
`define PPFS_DAT_RST 1'b0
`define PPFS_FUNC_RST 1'b0

// ==========================================================
// port 2 pin positions of the serial functions
// ==========================================================
`define PPFS_P2_TX0 0
`define PPFS_P2_CLK0 1
`define PPFS_P2_RX0 2
`define PPFS_P2_TX1 3
`define PPFS_P2_CLK1 4
`define PPFS_P2_RX1 5

`endif

// [ppfs_pin_cell.v]
// ppfs_pin_cell: registered pad logic for a group of port bits
// assumes config comes from flip-flops and pad inputs are synchronous
`timescale 1ns/1ns

module ppfs_pin_cell #(
  parameter W = 2
) (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire [W-1:0] dir_i,
  input wire [W-1:0] plu_i,
  input wire [W-1:0] dat_i,
  input wire [W-1:0] func_i,
  input wire [W-1:0] alt_out_i,
  input wire [W-1:0] pin_i,
  output reg [W-1:0] pin_o,
  output reg [W-1:0] pin_oe_o,
  output reg [W-1:0] pin_pu_o,
  output reg [W-1:0] read_o,
  output reg [W-1:0] alt_in_o
);

  // ========================================================
  // next values of the pad controls
  // ========================================================
  wire [W-1:0] pin_nxt; // alternate or latch data
  wire [W-1:0] pu_nxt; // pull-up gated by input mode
  wire [W-1:0] alt_in_nxt; // peripheral input when routed

  // output data: peripheral when selected, else the latch
  assign pin_nxt = (func_i & alt_out_i) | (~func_i & dat_i);
  // pull-up only while the pin is an input
  assign pu_nxt = plu_i & ~dir_i;
  // peripheral sees the pin only when selected and input
  assign alt_in_nxt = func_i & ~dir_i & pin_i;

  // ========================================================
  // pad registers
  // ========================================================
  // registered so pads never glitch on config decode
  always @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      pin_o <= {W{1'b0}};
      pin_oe_o <= {W{1'b0}};
      pin_pu_o <= {W{1'b0}};
      read_o <= {W{1'b0}};
      alt_in_o <= {W{1'b0}};
    end
    else
    begin
      pin_o <= pin_nxt;
      pin_oe_o <= dir_i; // direction bit drives enable
      pin_pu_o <= pu_nxt;
      read_o <= pin_i; // reads return the pin level
      alt_in_o <= alt_in_nxt;
    end
  end

endmodule // ppfs_pin_cell

// [ppfs_top.v]
// ppfs_top: direction, pull-up and data for ports 0, 2, 4, 5, 6, 8 and C,
// function select for ports 0, 2, 4 and 5, and routing to serial and timer blocks
// assumes one clock, synchronous pad inputs, and a cpu side that
// writes one field of one port per strobe
`timescale 1ns/1ns
`include "ppfs_consts.vh"

module ppfs_top (
  input wire clk_sys_i,
  input wire rstn_i,
  // configuration write port
  input wire cfg_we_i,
  input wire [2:0] cfg_port_i,
  input wire [1:0] cfg_field_i,
  input wire [7:0] cfg_wdata_i,
  // port 0 pads
  input wire [3:0] port0_pin_i,
  output wire [3:0] port0_pin_o,
  output wire [3:0] port0_pin_oe_o,
  output wire [3:0] port0_pullup_o,
  output wire [3:0] port0_read_o,
  // port 2 pads
  input wire [5:0] port2_pin_i,
  output wire [5:0] port2_pin_o,
  output wire [5:0] port2_pin_oe_o,
  output wire [5:0] port2_pullup_o,
  output wire [5:0] port2_read_o,
  // port 4 pads
  input wire [1:0] port4_pin_i,
  output wire [1:0] port4_pin_o,
  output wire [1:0] port4_pin_oe_o,
  output wire [1:0] port4_pullup_o,
  output wire [1:0] port4_read_o,
  // port 5 pads
  input wire [1:0] port5_pin_i,
  output wire [1:0] port5_pin_o,
  output wire [1:0] port5_pin_oe_o,
  output wire [1:0] port5_pullup_o,
  output wire [1:0] port5_read_o,
  // port 6 pads
  input wire [1:0] port6_pin_i,
  output wire [1:0] port6_pin_o,
  output wire [1:0] port6_pin_oe_o,
  output wire [1:0] port6_pullup_o,
  output wire [1:0] port6_read_o,
  // port 8 pads
  input wire [5:0] port8_pin_i,
  output wire [5:0] port8_pin_o,
  output wire [5:0] port8_pin_oe_o,
  output wire [5:0] port8_pullup_o,
  output wire [5:0] port8_read_o,
  // port C pads, bits 2 to 7
  input wire [7:2] portc_pin_i,
  output wire [7:2] portc_pin_o,
  output wire [7:2] portc_pin_oe_o,
  output wire [7:2] portc_pullup_o,
  output wire [7:2] portc_read_o,
  // serial channels
  input wire serial_tx_out_ch0_i,
  input wire serial_tx_out_ch1_i,
  input wire serial_clk_io_ch0_i,
  input wire serial_clk_io_ch1_i,
  output wire serial_rx_in_ch0_o,
  output wire serial_rx_in_ch1_o,
  output wire serial_clk_io_ch0_o,
  output wire serial_clk_io_ch1_o,
  // 8-bit timers 0,1,4,5,6,7 in bit order 0..5
  input wire [5:0] timer8_pulse_i,
  output wire [5:0] timer8_event_o,
  // 16-bit timer pins a and b
  input wire [1:0] wide_timer_out_i,
  output wire [1:0] wide_timer_event_o
);

  // ========================================================
  // configuration registers
  // ========================================================
  reg [3:0] port0_direction_r; // 1 = output
  reg [3:0] port0_pullup_enable_r; // 1 = pull-up wanted
  reg [3:0] port0_data_r; // output data latch
  reg [3:0] port0_function_select_r; // 1 = timer pin
  reg [5:0] port2_direction_r;
  reg [5:0] port2_pullup_enable_r;
  reg [5:0] port2_data_r;
  reg [5:0] port2_function_select_r; // 1 = serial pin
  reg [1:0] port4_direction_r;
  reg [1:0] port4_pullup_enable_r;
  reg [1:0] port4_data_r;
  reg [1:0] port4_function_select_r; // 1 = timer pin
  reg [1:0] port5_direction_r;
  reg [1:0] port5_pullup_enable_r;
  reg [1:0] port5_data_r;
  reg [1:0] port5_function_select_r; // 1 = wide timer pin
  reg [1:0] port6_direction_r;
  reg [1:0] port6_pullup_enable_r;
  reg [1:0] port6_data_r;
  reg [5:0] port8_direction_r;
  reg [5:0] port8_pullup_enable_r;
  reg [5:0] port8_data_r;
  reg [7:2] portc_direction_r;
  reg [7:2] portc_pullup_enable_r;
  reg [7:2] portc_data_r;

  // ========================================================
  // write decode
  // ========================================================
  // strobes for the four fields of one port, one bit per field
  // code; a write to the unmapped port code matches nothing
  function [3:0] wr_hit;
    input we;
    input [2:0] port;
    input [1:0] field;
    input [2:0] want_port;
    begin
      wr_hit = (we && port == want_port) ? 4'h1 << field : 4'h0;
    end
  endfunction

  // field strobes per port; plain ports leave the function strobe
  // unread, so a function write to them is dropped
  wire [3:0] we_p0 = wr_hit(cfg_we_i, cfg_port_i, cfg_field_i, `PPFS_PORT0);
  wire [3:0] we_p2 = wr_hit(cfg_we_i, cfg_port_i, cfg_field_i, `PPFS_PORT2);
  wire [3:0] we_p4 = wr_hit(cfg_we_i, cfg_port_i, cfg_field_i, `PPFS_PORT4);
  wire [3:0] we_p5 = wr_hit(cfg_we_i, cfg_port_i, cfg_field_i, `PPFS_PORT5);
  wire [3:0] we_p6 = wr_hit(cfg_we_i, cfg_port_i, cfg_field_i, `PPFS_PORT6);
  wire [3:0] we_p8 = wr_hit(cfg_we_i, cfg_port_i, cfg_field_i, `PPFS_PORT8);
  wire [3:0] we_pc = wr_hit(cfg_we_i, cfg_port_i, cfg_field_i, `PPFS_PORTC);

  // ========================================================
  // register update
  // ========================================================
  // every field resets to input, pull-up off, ordinary port;
  // unused data bits of a write are dropped
  always @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      port0_direction_r <= {4{`PPFS_DIR_RST}};
      port0_pullup_enable_r <= {4{`PPFS_PLU_RST}};
      port0_data_r <= {4{`PPFS_DAT_RST}};
      port0_function_select_r <= {4{`PPFS_FUNC_RST}};
      port2_direction_r <= {6{`PPFS_DIR_RST}};
      port2_pullup_enable_r <= {6{`PPFS_PLU_RST}};
      port2_data_r <= {6{`PPFS_DAT_RST}};
      port2_function_select_r <= {6{`PPFS_FUNC_RST}};
      port4_direction_r <= {2{`PPFS_DIR_RST}};
      port4_pullup_enable_r <= {2{`PPFS_PLU_RST}};
      port4_data_r <= {2{`PPFS_DAT_RST}};
      port4_function_select_r <= {2{`PPFS_FUNC_RST}};
      port5_direction_r <= {2{`PPFS_DIR_RST}};
      port5_pullup_enable_r <= {2{`PPFS_PLU_RST}};
      port5_data_r <= {2{`PPFS_DAT_RST}};
      port5_function_select_r <= {2{`PPFS_FUNC_RST}};
      port6_direction_r <= {2{`PPFS_DIR_RST}};
      port6_pullup_enable_r <= {2{`PPFS_PLU_RST}};
      port6_data_r <= {2{`PPFS_DAT_RST}};
      port8_direction_r <= {6{`PPFS_DIR_RST}};
      port8_pullup_enable_r <= {6{`PPFS_PLU_RST}};
      port8_data_r <= {6{`PPFS_DAT_RST}};
      portc_direction_r <= {6{`PPFS_DIR_RST}};
      portc_pullup_enable_r <= {6{`PPFS_PLU_RST}};
      portc_data_r <= {6{`PPFS_DAT_RST}};
    end
    else
    begin
      // port 0
      if (we_p0[`PPFS_FLD_DIR]) port0_direction_r <= cfg_wdata_i[3:0];
      if (we_p0[`PPFS_FLD_PLU]) port0_pullup_enable_r <= cfg_wdata_i[3:0];
      if (we_p0[`PPFS_FLD_DAT]) port0_data_r <= cfg_wdata_i[3:0];
      if (we_p0[`PPFS_FLD_FUNC]) port0_function_select_r <= cfg_wdata_i[3:0];
      // port 2
      if (we_p2[`PPFS_FLD_DIR]) port2_direction_r <= cfg_wdata_i[5:0];
      if (we_p2[`PPFS_FLD_PLU]) port2_pullup_enable_r <= cfg_wdata_i[5:0];
      if (we_p2[`PPFS_FLD_DAT]) port2_data_r <= cfg_wdata_i[5:0];
      if (we_p2[`PPFS_FLD_FUNC]) port2_function_select_r <= cfg_wdata_i[5:0];
      // port 4
      if (we_p4[`PPFS_FLD_DIR]) port4_direction_r <= cfg_wdata_i[1:0];
      if (we_p4[`PPFS_FLD_PLU]) port4_pullup_enable_r <= cfg_wdata_i[1:0];
      if (we_p4[`PPFS_FLD_DAT]) port4_data_r <= cfg_wdata_i[1:0];
      if (we_p4[`PPFS_FLD_FUNC]) port4_function_select_r <= cfg_wdata_i[1:0];
      // port 5
      if (we_p5[`PPFS_FLD_DIR]) port5_direction_r <= cfg_wdata_i[1:0];
      if (we_p5[`PPFS_FLD_PLU]) port5_pullup_enable_r <= cfg_wdata_i[1:0];
      if (we_p5[`PPFS_FLD_DAT]) port5_data_r <= cfg_wdata_i[1:0];
      if (we_p5[`PPFS_FLD_FUNC]) port5_function_select_r <= cfg_wdata_i[1:0];
      // port 6: plain port, per-bit direction and pull-up
      if (we_p6[`PPFS_FLD_DIR]) port6_direction_r <= cfg_wdata_i[1:0];
      if (we_p6[`PPFS_FLD_PLU]) port6_pullup_enable_r <= cfg_wdata_i[1:0];
      if (we_p6[`PPFS_FLD_DAT]) port6_data_r <= cfg_wdata_i[1:0];
      // port 8: plain port here, pwm routing lives elsewhere
      if (we_p8[`PPFS_FLD_DIR]) port8_direction_r <= cfg_wdata_i[5:0];
      if (we_p8[`PPFS_FLD_PLU]) port8_pullup_enable_r <= cfg_wdata_i[5:0];
      if (we_p8[`PPFS_FLD_DAT]) port8_data_r <= cfg_wdata_i[5:0];
      // port C: data bit n sits at write bit n
      if (we_pc[`PPFS_FLD_DIR]) portc_direction_r <= cfg_wdata_i[7:2];
      if (we_pc[`PPFS_FLD_PLU]) portc_pullup_enable_r <= cfg_wdata_i[7:2];
      if (we_pc[`PPFS_FLD_DAT]) portc_data_r <= cfg_wdata_i[7:2];
    end
  end

  // ========================================================
  // alternate output routing
  // ========================================================
  // receive pins have no peripheral output, so they keep the
  // latch; a receive pin set to output is thus an ordinary bit
  wire [5:0] port2_alt_out; // serial outputs by pin
  wire [5:0] port2_alt_in; // pins seen by the serial block
  wire [3:0] port0_alt_in; // timer 0,1,4,5 events
  wire [1:0] port4_alt_in; // timer 6,7 events
  wire [1:0] port5_alt_in; // wide timer events

  assign port2_alt_out = {port2_data_r[`PPFS_P2_RX1],
                          serial_clk_io_ch1_i,
                          serial_tx_out_ch1_i,
                          port2_data_r[`PPFS_P2_RX0],
                          serial_clk_io_ch0_i,
                          serial_tx_out_ch0_i};

  // ========================================================
  // alternate input routing
  // ========================================================
  // the cell gives zero when the function or input mode is off,
  // so a peripheral never sees an ordinary port bit
  assign serial_rx_in_ch0_o = port2_alt_in[`PPFS_P2_RX0];
  assign serial_rx_in_ch1_o = port2_alt_in[`PPFS_P2_RX1];
  assign serial_clk_io_ch0_o = port2_alt_in[`PPFS_P2_CLK0];
  assign serial_clk_io_ch1_o = port2_alt_in[`PPFS_P2_CLK1];
  assign timer8_event_o = {port4_alt_in, port0_alt_in};
  assign wide_timer_event_o = port5_alt_in;

  // ========================================================
  // pad cells
  // ========================================================
  // port 0: 8-bit timer pins 0,1,4,5
  ppfs_pin_cell #(.W(4)) u_port0 (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .dir_i(port0_direction_r), .plu_i(port0_pullup_enable_r),
    .dat_i(port0_data_r),
    .func_i(port0_function_select_r),
    .alt_out_i(timer8_pulse_i[3:0]),
    .pin_i(port0_pin_i), .pin_o(port0_pin_o),
    .pin_oe_o(port0_pin_oe_o), .pin_pu_o(port0_pullup_o),
    .read_o(port0_read_o), .alt_in_o(port0_alt_in)
  );

  // port 2: serial channels 0 and 1
  ppfs_pin_cell #(.W(6)) u_port2 (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .dir_i(port2_direction_r), .plu_i(port2_pullup_enable_r),
    .dat_i(port2_data_r), .alt_out_i(port2_alt_out),
    .func_i(port2_function_select_r),
    .pin_i(port2_pin_i), .pin_o(port2_pin_o),
    .pin_oe_o(port2_pin_oe_o), .pin_pu_o(port2_pullup_o),
    .read_o(port2_read_o), .alt_in_o(port2_alt_in)
  );

  // port 4: 8-bit timer pins 6,7
  ppfs_pin_cell #(.W(2)) u_port4 (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .dir_i(port4_direction_r), .plu_i(port4_pullup_enable_r),
    .dat_i(port4_data_r),
    .func_i(port4_function_select_r),
    .alt_out_i(timer8_pulse_i[5:4]),
    .pin_i(port4_pin_i), .pin_o(port4_pin_o),
    .pin_oe_o(port4_pin_oe_o), .pin_pu_o(port4_pullup_o),
    .read_o(port4_read_o), .alt_in_o(port4_alt_in)
  );

  // port 5: wide timer; timer or pwm choice is the timer's own
  ppfs_pin_cell #(.W(2)) u_port5 (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .dir_i(port5_direction_r), .plu_i(port5_pullup_enable_r),
    .dat_i(port5_data_r),
    .func_i(port5_function_select_r),
    .alt_out_i(wide_timer_out_i),
    .pin_i(port5_pin_i), .pin_o(port5_pin_o),
    .pin_oe_o(port5_pin_oe_o), .pin_pu_o(port5_pullup_o),
    .read_o(port5_read_o), .alt_in_o(port5_alt_in)
  );

  // port 6: no alternate function
  ppfs_pin_cell #(.W(2)) u_port6 (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .dir_i(port6_direction_r), .plu_i(port6_pullup_enable_r),
    .dat_i(port6_data_r), .func_i(2'h0), .alt_out_i(2'h0),
    .pin_i(port6_pin_i), .pin_o(port6_pin_o),
    .pin_oe_o(port6_pin_oe_o), .pin_pu_o(port6_pullup_o),
    .read_o(port6_read_o), .alt_in_o()
  );

  // port 8: no alternate function in this block
  ppfs_pin_cell #(.W(6)) u_port8 (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .dir_i(port8_direction_r), .plu_i(port8_pullup_enable_r),
    .dat_i(port8_data_r), .func_i(6'h00), .alt_out_i(6'h00),
    .pin_i(port8_pin_i), .pin_o(port8_pin_o),
    .pin_oe_o(port8_pin_oe_o), .pin_pu_o(port8_pullup_o),
    .read_o(port8_read_o), .alt_in_o()
  );

  // port C: analog use is decided outside this block
  ppfs_pin_cell #(.W(6)) u_portc (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .dir_i(portc_direction_r), .plu_i(portc_pullup_enable_r),
    .dat_i(portc_data_r), .func_i(6'h00), .alt_out_i(6'h00),
    .pin_i(portc_pin_i), .pin_o(portc_pin_o),
    .pin_oe_o(portc_pin_oe_o), .pin_pu_o(portc_pullup_o),
    .read_o(portc_read_o), .alt_in_o()
  );

endmodule // ppfs_top

// [ppfs_top_assertions.sv]
// checker for ppfs_top: pad and alternate-input timing seen at the ports
// assumes it is bound to ppfs_top and sees only that module's ports
`timescale 1ns/1ns

module ppfs_top_chk (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire cfg_we_i,
  input wire [5:0] port2_pin_i,
  input wire [5:0] port2_pin_oe_o,
  input wire [1:0] port4_pin_i,
  input wire [1:0] port4_pin_oe_o,
  input wire [1:0] port5_pin_i,
  input wire [1:0] port5_pin_oe_o,
  input wire [1:0] port6_pin_oe_o,
  input wire [1:0] port6_pullup_o,
  input wire [5:0] port8_pin_i,
  input wire [5:0] port8_pin_oe_o,
  input wire [5:0] port8_pullup_o,
  input wire [5:0] port8_read_o,
  input wire [7:2] portc_pin_oe_o,
  input wire [7:2] portc_pullup_o,
  input wire serial_rx_in_ch0_o,
  input wire serial_clk_io_ch1_o,
  input wire [5:0] timer8_event_o,
  input wire [1:0] wide_timer_event_o
);
  // ==========================================================
  // one clock domain, so clock and reset are given once
  // ==========================================================
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);
  // the edge after reset must still show idle pads
  property p_rst_pads;
    !$past(rstn_i) |-> ({port6_pin_oe_o, port8_pin_oe_o, portc_pin_oe_o,
      port6_pullup_o, port8_pullup_o, portc_pullup_o} == 28'h0);
  endproperty
  a_rst_pads: assert property (p_rst_pads)
    else $error("pads not idle after reset");
  // a driven pad never has its pull-up on as well
  property p_pu_in_only;
    !(|(port6_pullup_o & port6_pin_oe_o)) && !(|(port8_pullup_o &
      port8_pin_oe_o)) && !(|(portc_pullup_o & portc_pin_oe_o));
  endproperty
  a_pu_in_only: assert property (p_pu_in_only)
    else $error("pull-up on while pad drives");
  property p_read8;
    $past(rstn_i) |-> port8_read_o == $past(port8_pin_i);
  endproperty
  a_read8: assert property (p_read8)
    else $error("read value is not the pad level");
  property p_rx0;
    serial_rx_in_ch0_o |-> !port2_pin_oe_o[2] && $past(port2_pin_i[2]);
  endproperty
  a_rx0: assert property (p_rx0)
    else $error("receive data without input pad high");
  property p_clk1;
    serial_clk_io_ch1_o |-> !port2_pin_oe_o[4] && $past(port2_pin_i[4]);
  endproperty
  a_clk1: assert property (p_clk1)
    else $error("serial clock in while pad drives");
  property p_tmr_ev;
    timer8_event_o[4] |-> !port4_pin_oe_o[0] && $past(port4_pin_i[0]);
  endproperty
  a_tmr_ev: assert property (p_tmr_ev)
    else $error("timer event without input pad high");
  property p_wide_ev;
    wide_timer_event_o[1] |-> !port5_pin_oe_o[1] && $past(port5_pin_i[1]);
  endproperty
  a_wide_ev: assert property (p_wide_ev)
    else $error("wide timer event without input pad high");
  // direction only moves two edges after a write
  property p_dir_hold;
    !cfg_we_i ##1 !cfg_we_i |=> $stable(port6_pin_oe_o);
  endproperty
  a_dir_hold: assert property (p_dir_hold)
    else $error("drive enable moved with no write");
endmodule // ppfs_top_chk

bind ppfs_top ppfs_top_chk u_chk (
  .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cfg_we_i(cfg_we_i),
  .port2_pin_i(port2_pin_i), .port2_pin_oe_o(port2_pin_oe_o),
  .port4_pin_i(port4_pin_i), .port4_pin_oe_o(port4_pin_oe_o),
  .port5_pin_i(port5_pin_i), .port5_pin_oe_o(port5_pin_oe_o),
  .port6_pin_oe_o(port6_pin_oe_o), .port6_pullup_o(port6_pullup_o),
  .port8_pin_i(port8_pin_i), .port8_pin_oe_o(port8_pin_oe_o),
  .port8_pullup_o(port8_pullup_o), .port8_read_o(port8_read_o),
  .portc_pin_oe_o(portc_pin_oe_o), .portc_pullup_o(portc_pullup_o),
  .serial_rx_in_ch0_o(serial_rx_in_ch0_o),
  .serial_clk_io_ch1_o(serial_clk_io_ch1_o),
  .timer8_event_o(timer8_event_o),
  .wide_timer_event_o(wide_timer_event_o)
);

// [ppfs_top_test.sv]
// testbench for ppfs_top: random port configs, pads and peripherals
// assumes the design and checker files are compiled before it
`timescale 1ns/1ns
`include "ppfs_consts.vh"

module ppfs_top_test;
  // ==========================================================
  // stimulus state, indexed by port code
  // ==========================================================
  reg clk_sys_i = 1'b0;
  reg rstn_i = 1'b0;
  reg cfg_we_i = 1'b0;
  reg [2:0] cfg_port_i = 3'h0;
  reg [1:0] cfg_field_i = 2'h0;
  reg [7:0] cfg_wdata_i = 8'h00;
  reg [7:0] pin [0:6]; // pad levels
  reg [7:0] dir [0:6], plu [0:6], dat [0:6], fn [0:6]; // expected config
  reg [5:0] pulse; // 8-bit timer pulses
  reg [1:0] wide; // wide timer outputs
  reg [3:0] ser; // {clk1, tx1, clk0, tx0}
  integer mismatches = 0;
  integer checked = 0;
  integer it, p, r;
  wire [3:0] port0_pin_o, port0_pin_oe_o, port0_pullup_o, port0_read_o;
  wire [5:0] port2_pin_o, port2_pin_oe_o, port2_pullup_o, port2_read_o;
  wire [1:0] port4_pin_o, port4_pin_oe_o, port4_pullup_o, port4_read_o;
  wire [1:0] port5_pin_o, port5_pin_oe_o, port5_pullup_o, port5_read_o;
  wire [1:0] port6_pin_o, port6_pin_oe_o, port6_pullup_o, port6_read_o;
  wire [5:0] port8_pin_o, port8_pin_oe_o, port8_pullup_o, port8_read_o;
  wire [7:2] portc_pin_o, portc_pin_oe_o, portc_pullup_o, portc_read_o;
  wire serial_rx_in_ch0_o, serial_rx_in_ch1_o;
  wire serial_clk_io_ch0_o, serial_clk_io_ch1_o;
  wire [5:0] timer8_event_o;
  wire [1:0] wide_timer_event_o;
  ppfs_top u_dut (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cfg_we_i(cfg_we_i),
    .cfg_port_i(cfg_port_i), .cfg_field_i(cfg_field_i),
    .cfg_wdata_i(cfg_wdata_i), .port0_pin_i(pin[0][3:0]),
    .port0_pin_o(port0_pin_o), .port0_pin_oe_o(port0_pin_oe_o),
    .port0_pullup_o(port0_pullup_o), .port0_read_o(port0_read_o),
    .port2_pin_i(pin[1][5:0]), .port2_pin_o(port2_pin_o),
    .port2_pin_oe_o(port2_pin_oe_o), .port2_pullup_o(port2_pullup_o),
    .port2_read_o(port2_read_o), .port4_pin_i(pin[2][1:0]),
    .port4_pin_o(port4_pin_o), .port4_pin_oe_o(port4_pin_oe_o),
    .port4_pullup_o(port4_pullup_o), .port4_read_o(port4_read_o),
    .port5_pin_i(pin[3][1:0]), .port5_pin_o(port5_pin_o),
    .port5_pin_oe_o(port5_pin_oe_o), .port5_pullup_o(port5_pullup_o),
    .port5_read_o(port5_read_o), .port6_pin_i(pin[4][1:0]),
    .port6_pin_o(port6_pin_o), .port6_pin_oe_o(port6_pin_oe_o),
    .port6_pullup_o(port6_pullup_o), .port6_read_o(port6_read_o),
    .port8_pin_i(pin[5][5:0]), .port8_pin_o(port8_pin_o),
    .port8_pin_oe_o(port8_pin_oe_o), .port8_pullup_o(port8_pullup_o),
    .port8_read_o(port8_read_o), .portc_pin_i(pin[6][7:2]),
    .portc_pin_o(portc_pin_o), .portc_pin_oe_o(portc_pin_oe_o),
    .portc_pullup_o(portc_pullup_o), .portc_read_o(portc_read_o),
    .serial_tx_out_ch0_i(ser[0]), .serial_clk_io_ch0_i(ser[1]),
    .serial_tx_out_ch1_i(ser[2]), .serial_clk_io_ch1_i(ser[3]),
    .serial_rx_in_ch0_o(serial_rx_in_ch0_o),
    .serial_rx_in_ch1_o(serial_rx_in_ch1_o),
    .serial_clk_io_ch0_o(serial_clk_io_ch0_o),
    .serial_clk_io_ch1_o(serial_clk_io_ch1_o),
    .timer8_pulse_i(pulse), .timer8_event_o(timer8_event_o),
    .wide_timer_out_i(wide), .wide_timer_event_o(wide_timer_event_o)
  );
  initial
  begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // ==========================================================
  // expectation helpers
  // ==========================================================
  function [7:0] msk(input [2:0] q); // implemented bits of a port
    case (q)
      3'h0: msk = 8'h0f;
      3'h2, 3'h3, 3'h4: msk = 8'h03;
      3'h6: msk = 8'hfc;
      default: msk = 8'h3f;
    endcase
  endfunction
  // alternate value offered to each pad; receive pins keep the latch
  function [7:0] per(input [2:0] q);
    case (q)
      3'h0: per = {4'h0, pulse[3:0]};
      3'h1: per = {2'h0, dat[1][5], ser[3:2], dat[1][2], ser[1:0]};
      3'h2: per = {6'h00, pulse[5:4]};
      3'h3: per = {6'h00, wide};
      default: per = dat[q];
    endcase
  endfunction
  function [31:0] act(input [2:0] q); // {oe, pull-up, out, read}
    case (q)
      3'h0: act = {4'h0, port0_pin_oe_o, 4'h0, port0_pullup_o,
                   4'h0, port0_pin_o, 4'h0, port0_read_o};
      3'h1: act = {2'h0, port2_pin_oe_o, 2'h0, port2_pullup_o,
                   2'h0, port2_pin_o, 2'h0, port2_read_o};
      3'h2: act = {6'h00, port4_pin_oe_o, 6'h00, port4_pullup_o,
                   6'h00, port4_pin_o, 6'h00, port4_read_o};
      3'h3: act = {6'h00, port5_pin_oe_o, 6'h00, port5_pullup_o,
                   6'h00, port5_pin_o, 6'h00, port5_read_o};
      3'h4: act = {6'h00, port6_pin_oe_o, 6'h00, port6_pullup_o,
                   6'h00, port6_pin_o, 6'h00, port6_read_o};
      3'h5: act = {2'h0, port8_pin_oe_o, 2'h0, port8_pullup_o,
                   2'h0, port8_pin_o, 2'h0, port8_read_o};
      default: act = {portc_pin_oe_o, 2'h0, portc_pullup_o, 2'h0,
                      portc_pin_o, 2'h0, portc_read_o, 2'h0};
    endcase
  endfunction
  task chk_pad(input [7:0] a, input [7:0] e);
    begin
      checked = checked + 1;
      if (a !== e)
      begin
        mismatches = mismatches + 1;
        $display("[ERR] %0t port %0d pad got %h want %h", $time, p, a, e);
      end
    end
  endtask
  task chk_alt(input [11:0] a, input [11:0] e);
    begin
      checked = checked + 1;
      if (a !== e)
      begin
        mismatches = mismatches + 1;
        $display("[ERR] %0t alt inputs got %h want %h", $time, a, e);
      end
    end
  endtask
  // ==========================================================
  // bus-less config write; strobe held high across a batch
  // ==========================================================
  task cfg(input [2:0] q, input [1:0] f, input [7:0] v);
    begin
      cfg_we_i = 1'b1;
      cfg_port_i = q;
      cfg_field_i = f;
      cfg_wdata_i = v;
      if (f == `PPFS_FLD_DIR && q != 3'h7) dir[q] = v;
      if (f == `PPFS_FLD_PLU && q != 3'h7) plu[q] = v;
      if (f == `PPFS_FLD_DAT && q != 3'h7) dat[q] = v;
      if (f == `PPFS_FLD_FUNC && q < 3'h4) fn[q] = v; // others refused
      @(posedge clk_sys_i);
      #1;
    end
  endtask
  task check_all;
    reg [31:0] a;
    reg [7:0] m, e0, e1, e2, e3;
    reg [11:0] aa, ea; // alternate inputs got and wanted
    begin
      for (p = 0; p < 7; p = p + 1)
      begin
        a = act(p[2:0]);
        m = msk(p[2:0]);
        chk_pad(a[31:24], dir[p] & m);
        chk_pad(a[23:16], plu[p] & ~dir[p] & m);
        e0 = (fn[p] & per(p[2:0])) | (~fn[p] & dat[p]);
        chk_pad(a[15:8], e0 & m);
        chk_pad(a[7:0], pin[p] & m);
      end
      e0 = fn[0] & ~dir[0] & pin[0];
      e1 = fn[1] & ~dir[1] & pin[1];
      e2 = fn[2] & ~dir[2] & pin[2];
      e3 = fn[3] & ~dir[3] & pin[3];
      aa = {timer8_event_o, wide_timer_event_o, serial_rx_in_ch1_o,
        serial_rx_in_ch0_o, serial_clk_io_ch1_o, serial_clk_io_ch0_o};
      ea = {e2[1:0], e0[3:0], e3[1:0], e1[5], e1[2], e1[4], e1[1]};
      chk_alt(aa, ea);
    end
  endtask
  task do_reset; // 16 edges low, then idle pads expected
    begin
      rstn_i = 1'b0;
      for (p = 0; p < 7; p = p + 1)
      begin
        pin[p] = 8'h00;
        dir[p] = 8'h00;
        plu[p] = 8'h00;
        dat[p] = 8'h00;
        fn[p] = 8'h00;
      end
      pulse = 6'h00;
      wide = 2'h0;
      ser = 4'h0;
      repeat (16) @(posedge clk_sys_i);
      #1;
      rstn_i = 1'b1;
      check_all;
    end
  endtask
  task test_done;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial
  begin
    #100000;
    mismatches = mismatches + 1;
    test_done;
  end
  // corners first: all output with all alternates, then all input
  initial
  begin
    r = $urandom(66);
    do_reset;
    for (it = 0; it < 60; it = it + 1)
    begin
      if (it == 30) do_reset;
      for (r = 0; r < 8; r = r + 1)
      begin
        cfg(r[2:0], `PPFS_FLD_DIR, it == 0 ? 8'hff : it == 1 ? 8'h00 :
          8'($urandom));
        cfg(r[2:0], `PPFS_FLD_PLU, 8'($urandom));
        cfg(r[2:0], `PPFS_FLD_DAT, 8'($urandom));
        cfg(r[2:0], `PPFS_FLD_FUNC, it < 2 ? 8'hff : 8'($urandom));
      end
      cfg_we_i = 1'b0;
      for (p = 0; p < 7; p = p + 1) pin[p] = 8'($urandom);
      pulse = 6'($urandom);
      wide = 2'($urandom);
      ser = 4'($urandom);
      // two idle edges, so the no-write hold check gets exercised
      repeat (2) @(posedge clk_sys_i);
      #1;
      check_all;
    end
    test_done;
  end
endmodule // ppfs_top_test
